// [hdl/mtse_pkg.sv]
// Package: constants and types for the multitag signalling serial encoder
package mtse_pkg;
   localparam int unsigned CLK_HZ = 200_000_000; // Core clock rate
   localparam int unsigned BIT_MS = 20; // Signalling bit time
   localparam int unsigned GAP_MS = 200; // Idle gap after each frame
   localparam int unsigned BIT_CYC = CLK_HZ / 1000 * BIT_MS; // Cycles per bit
   localparam int unsigned GAP_CYC = CLK_HZ / 1000 * GAP_MS; // Cycles per gap
   localparam int unsigned ID_BITS = 8; // Identifier bits per frame
   localparam int unsigned TAG_NUM = 16; // Size of the tag table
   localparam int unsigned FIFO_DEPTH = 8; // Identifier FIFO depth
   localparam logic [7:0] ASCII_ZERO = 8'h30; // Character '0'
   localparam logic [7:0] ASCII_A = 8'h41; // Character 'A'
   localparam logic [3:0] DIGIT_TEN = 4'hA; // First letter digit
   localparam logic START_LVL = 1'b1; // Start bit level
   localparam logic IDLE_LVL = 1'b0; // Idle line level

   // Programming modes
   typedef enum logic [2:0] {
      MTSE_BASIC_NO_SIGNAL,
      MTSE_SINGLE_TAG,
      MTSE_POSITIONAL_TWO_TAG_PROGRAM,
      MTSE_IDENTIFYING_TWO_TAG_PROGRAM,
      MTSE_IDENTIFYING_THREE_TAG_PROGRAM,
      MTSE_IDENTIFYING_FOUR_TAG_PROGRAM,
      MTSE_IDENTIFYING_SIXTEEN_TAG_PROGRAM
   } mtse_prog_t;

   // Recognised actuator report
   typedef struct packed {
      logic present; // Tag in safe zone
      logic [3:0] index; // Tag index
   } mtse_tag_t;

   // Per-tag behaviour table entry
   typedef struct packed {
      logic safety_en; // Tag may enable safety outputs
      logic signal_only; // Tag drives signalling output only
      logic send_id; // Tag identifier is transmitted
   } mtse_beh_t;
endpackage : mtse_pkg

// [hdl/mtse_fifo.sv]
// Module: small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module mtse_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH); // Pointer width
   logic [WIDTH-1:0] mem [DEPTH]; // Storage array
   logic [AW-1:0] wr_q; // Write pointer
   logic [AW-1:0] rd_q; // Read pointer
   logic [AW:0] cnt_q; // Occupancy
   logic push; // Accepted write
   logic pop; // Accepted read

   assign in_ready = (cnt_q != (AW+1)'(DEPTH)); // Full at DEPTH entries
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];
   assign push = in_valid && in_ready && ce;
   assign pop = out_valid && out_ready && ce;

   // Storage write, no reset needed on data
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= AW'(wr_q + 1'b1);
         end
         if (pop) begin
            rd_q <= AW'(rd_q + 1'b1);
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule : mtse_fifo

// [hdl/mtse_top.sv]
// Module: tag-to-output mapping and serial identifier encoder
//
// Notes on behaviour
// - Inverted variant outside basic: signal active when all off
// - Table of sixteen tag behaviours held
// - Positional: actuator_index_zero safety, actuator_index_one signalling only
// - Identifying programs: safety plus index sent
// - Identifier is ASCII hex digit character
// - Frame opens with one high start bit
// - Line low right after last bit
// - Two hundred ms idle gap between frames
// - Each bit lasts twenty ms
// - Stream only while multitag tag present
// - Basic variant keeps signalling output off
// - Safety outputs need inputs and zone
`timescale 1ns/1ps
module mtse_top (
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic CLK_EN,
   input wire mtse_pkg::mtse_prog_t PROGRAM_SEL,
   input wire logic SIGNAL_INVERTED,
   input wire logic TAG_PRESENT,
   input wire logic [3:0] TAG_INDEX,
   input wire logic SAFETY_INPUT_A,
   input wire logic SAFETY_INPUT_B,
   output logic SAFETY_OUTPUT_A,
   output logic SAFETY_OUTPUT_B,
   output logic SIGNALLING_OUTPUT,
   output logic FRAME_BUSY
);
   import mtse_pkg::*;

   // Encoder states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_START,
      ST_DATA,
      ST_GAP
   } mtse_state_t;

   // Pin synchronisers, two stages each
   logic [1:0] sync1_q; // First stage, read only by second stage
   logic [1:0] sync2_q; // Second stage
   mtse_tag_t tag; // Synchronised tag report
   logic in_a; // Synchronised safety input A
   logic in_b; // Synchronised safety input B
   mtse_tag_t tag_sync1_q; // First stage of the tag bus
   mtse_tag_t tag_q; // Second stage of the tag bus

   // Behaviour table, one entry per tag
   mtse_beh_t beh_table [TAG_NUM]; // Decoded behaviour per tag
   mtse_beh_t beh; // Behaviour of the current tag

   logic safety_ok; // Safety outputs may switch on
   logic sig_static; // Static signalling level
   logic stream_en; // Identifier stream allowed
   logic [7:0] id_char; // ASCII character of the tag

   // Encoder registers
   mtse_state_t state_q; // Encoder state
   logic [31:0] tmr_q; // Bit and gap timer
   logic [2:0] bit_q; // Data bit index
   logic [7:0] shift_q; // Character being sent
   logic line_q; // Serial line level
   logic fifo_valid; // Character waiting
   logic [7:0] fifo_data; // Character at FIFO head
   logic fifo_in_ready; // FIFO can accept
   logic fifo_pop; // Encoder takes a character
   logic load_q; // One character per frame enqueued

   // Synchronise safety inputs; the tag bus is assumed stable across samples
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         sync1_q <= '0;
         sync2_q <= '0;
         tag_sync1_q <= '0;
         tag_q <= '0;
      end else if (CLK_EN) begin
         sync1_q <= {SAFETY_INPUT_B, SAFETY_INPUT_A};
         sync2_q <= sync1_q;
         tag_sync1_q <= '{present: TAG_PRESENT, index: TAG_INDEX};
         tag_q <= tag_sync1_q;
      end
   end
   assign in_a = sync2_q[0];
   assign in_b = sync2_q[1];
   assign tag = tag_q;

   // Behaviour table built from the programming, one entry per tag
   genvar gi;
   generate
      for (gi = 0; gi < TAG_NUM; gi++) begin : g_tab
         always_comb begin
            beh_table[gi] = '0;
            case (PROGRAM_SEL)
               MTSE_SINGLE_TAG: beh_table[gi].safety_en = (gi == 0);
               MTSE_POSITIONAL_TWO_TAG_PROGRAM: begin
                  beh_table[gi].safety_en = (gi == 0);
                  beh_table[gi].signal_only = (gi == 1);
               end
               MTSE_IDENTIFYING_TWO_TAG_PROGRAM: begin
                  beh_table[gi].safety_en = (gi < 2);
                  beh_table[gi].send_id = (gi < 2);
               end
               MTSE_IDENTIFYING_THREE_TAG_PROGRAM: begin
                  beh_table[gi].safety_en = (gi < 3);
                  beh_table[gi].send_id = (gi < 3);
               end
               MTSE_IDENTIFYING_FOUR_TAG_PROGRAM: begin
                  beh_table[gi].safety_en = (gi < 4);
                  beh_table[gi].send_id = (gi < 4);
               end
               MTSE_IDENTIFYING_SIXTEEN_TAG_PROGRAM: begin
                  beh_table[gi].safety_en = 1'b1;
                  beh_table[gi].send_id = 1'b1;
               end
               default: beh_table[gi] = '0;
            endcase
         end
      end
   endgenerate

   // Current tag behaviour, blank when nothing is recognised
   assign beh = tag.present ? beh_table[tag.index] : '0;
   assign safety_ok = beh.safety_en && in_a && in_b;
   assign stream_en = beh.send_id && (PROGRAM_SEL != MTSE_BASIC_NO_SIGNAL);
   assign id_char = (tag.index < DIGIT_TEN) ? ASCII_ZERO + {4'h0, tag.index}
                  : ASCII_A + {4'h0, tag.index - DIGIT_TEN};

   // Static signalling level when no stream runs
   always_comb begin
      if (PROGRAM_SEL == MTSE_BASIC_NO_SIGNAL) begin
         sig_static = 1'b0;
      end else if (SIGNAL_INVERTED) begin
         sig_static = !tag.present && !safety_ok;
      end else begin
         // Positional tag zero keeps the line low so open and closed stay distinct
         sig_static = beh.signal_only
                    || (beh.safety_en && !beh.send_id && PROGRAM_SEL == MTSE_SINGLE_TAG);
      end
   end

   // Identifier FIFO; a stall here holds back the next frame
   mtse_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(CORE_CLK),
      .rst_n(RESETN),
      .ce(CLK_EN),
      .in_valid(stream_en && !load_q),
      .in_ready(fifo_in_ready),
      .in_data(id_char),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );
   // Without a tag any waiting character is stale, so it is drained
   assign fifo_pop = !stream_en || (state_q == ST_IDLE);

   // Enqueue one character per frame; rearmed when the gap ends
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         load_q <= 1'b0;
      end else if (CLK_EN) begin
         if (!stream_en) begin
            load_q <= 1'b0;
         end else if (fifo_in_ready && !load_q) begin
            load_q <= 1'b1;
         end else if (state_q == ST_GAP && tmr_q == 32'(GAP_CYC - 1)) begin
            load_q <= 1'b0;
         end
      end
   end

   // Frame sequencer: start bit, eight data bits, then idle gap
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         state_q <= ST_IDLE;
         tmr_q <= '0;
         bit_q <= '0;
         shift_q <= '0;
         line_q <= IDLE_LVL;
      end else if (CLK_EN) begin
         case (state_q)
            ST_IDLE: begin
               line_q <= IDLE_LVL;
               tmr_q <= '0;
               if (fifo_valid && stream_en) begin
                  shift_q <= fifo_data;
                  line_q <= START_LVL;
                  state_q <= ST_START;
               end
            end
            ST_START: begin
               tmr_q <= tmr_q + 1'b1;
               if (tmr_q == 32'(BIT_CYC - 1)) begin
                  tmr_q <= '0;
                  bit_q <= '0;
                  line_q <= shift_q[ID_BITS-1];
                  shift_q <= {shift_q[6:0], 1'b0};
                  state_q <= ST_DATA;
               end
            end
            ST_DATA: begin
               tmr_q <= tmr_q + 1'b1;
               if (tmr_q == 32'(BIT_CYC - 1)) begin
                  tmr_q <= '0;
                  bit_q <= bit_q + 1'b1;
                  if (bit_q == 3'(ID_BITS - 1)) begin
                     line_q <= IDLE_LVL;
                     state_q <= ST_GAP;
                  end else begin
                     line_q <= shift_q[ID_BITS-1];
                     shift_q <= {shift_q[6:0], 1'b0};
                  end
               end
            end
            ST_GAP: begin
               line_q <= IDLE_LVL;
               tmr_q <= tmr_q + 1'b1;
               if (tmr_q == 32'(GAP_CYC - 1)) begin
                  tmr_q <= '0;
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
         // Lost tag cuts the frame, so a new tag never inherits its tail
         if (!stream_en) begin
            state_q <= ST_IDLE;
            tmr_q <= '0;
            line_q <= IDLE_LVL;
         end
      end
   end

   // Registered pins; a lost tag ends the stream and the frame in progress
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         SAFETY_OUTPUT_A <= 1'b0;
         SAFETY_OUTPUT_B <= 1'b0;
         SIGNALLING_OUTPUT <= 1'b0;
         FRAME_BUSY <= 1'b0;
      end else if (CLK_EN) begin
         SAFETY_OUTPUT_A <= safety_ok;
         SAFETY_OUTPUT_B <= safety_ok;
         SIGNALLING_OUTPUT <= stream_en ? line_q : sig_static;
         FRAME_BUSY <= (state_q != ST_IDLE);
      end
   end
endmodule : mtse_top

// [test/mtse_plc_model.sv]
// Partner: behavioural receiver decoding the signalling line
`timescale 1ns/1ps
module mtse_plc_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic line,
   output logic [7:0] rx_char,
   output logic rx_valid
);
   import mtse_pkg::*;
   int unsigned wait_q; // Cycles to next sample
   int nbit_q; // Bit slot, -1 while hunting
   // Mid-bit sampling keeps clear of edge jitter
   always_ff @(posedge clk) begin
      rx_valid <= 1'b0;
      if (!rst_n) begin
         nbit_q <= -1;
         wait_q <= 0;
      end else if (nbit_q < 0) begin
         if (line) begin // Start bit seen
            nbit_q <= 0;
            wait_q <= BIT_CYC + BIT_CYC / 2;
         end
      end else if (wait_q != 0) begin
         wait_q <= wait_q - 1;
      end else begin // Take one bit
         rx_char <= {rx_char[6:0], line};
         wait_q <= BIT_CYC - 1;
         nbit_q <= (nbit_q == 7) ? -1 : nbit_q + 1;
         rx_valid <= (nbit_q == 7);
      end
   end
endmodule : mtse_plc_model

// [test/mtse_top_properties.sv]
// Checker: port-level properties of the serial encoder
`timescale 1ns/1ps
module mtse_top_properties (
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic CLK_EN,
   input wire mtse_pkg::mtse_prog_t PROGRAM_SEL,
   input wire logic SIGNAL_INVERTED,
   input wire logic TAG_PRESENT,
   input wire logic [3:0] TAG_INDEX,
   input wire logic SAFETY_INPUT_A,
   input wire logic SAFETY_INPUT_B,
   input wire logic SAFETY_OUTPUT_A,
   input wire logic SAFETY_OUTPUT_B,
   input wire logic SIGNALLING_OUTPUT,
   input wire logic FRAME_BUSY
);
   import mtse_pkg::*;
   logic id_m; // Identifying mode, plain polarity
   logic [31:0] hi_q; // Cycles the line has been high
   assign id_m = PROGRAM_SEL >= MTSE_IDENTIFYING_TWO_TAG_PROGRAM && !SIGNAL_INVERTED;
   // High-time counter, cleared whenever the line is low
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN || !SIGNALLING_OUTPUT) hi_q <= 32'h0;
      else hi_q <= hi_q + 32'h1;
   end
   default clocking @(posedge CORE_CLK); endclocking
   // A frozen clock enable stretches every latency, so such cycles are not judged
   default disable iff (!RESETN || !CLK_EN);
   a_basic_silent: assert property (PROGRAM_SEL == MTSE_BASIC_NO_SIGNAL |->
      !SIGNALLING_OUTPUT) else $error("signal active in basic mode");
   a_safety_gate: assert property (CLK_EN && (!SAFETY_INPUT_A || !SAFETY_INPUT_B ||
      !TAG_PRESENT) |-> ##3 (!SAFETY_OUTPUT_A && !SAFETY_OUTPUT_B))
      else $error("safety on without cause");
   a_start_hold: assert property ($rose(SIGNALLING_OUTPUT) && id_m |->
      (SIGNALLING_OUTPUT || !TAG_PRESENT) [*8]) else $error("start bit too short");
   a_bit_time: assert property ($fell(SIGNALLING_OUTPUT) && id_m && TAG_PRESENT &&
      FRAME_BUSY |-> (hi_q % BIT_CYC) == 0) else $error("bit time wrong");
   a_idle_low: assert property (id_m && !FRAME_BUSY |-> !SIGNALLING_OUTPUT)
      else $error("line high while idle");
   a_stream_tag: assert property ((id_m && !TAG_PRESENT) [*4] |-> !SIGNALLING_OUTPUT)
      else $error("stream without tag");
   a_inv_wiring: assert property ((SIGNAL_INVERTED && PROGRAM_SEL != MTSE_BASIC_NO_SIGNAL &&
      !TAG_PRESENT) [*6] |-> SIGNALLING_OUTPUT) else $error("inverted line not active");
   a_pos_actuator_index_one: assert property ((PROGRAM_SEL == MTSE_POSITIONAL_TWO_TAG_PROGRAM &&
      TAG_PRESENT && TAG_INDEX == 4'h1 && !SIGNAL_INVERTED) [*6] |->
      SIGNALLING_OUTPUT && !SAFETY_OUTPUT_A) else $error("tag one mapping wrong");
   a_refuse_idx: assert property (PROGRAM_SEL == MTSE_IDENTIFYING_TWO_TAG_PROGRAM &&
      TAG_INDEX > 4'h1 |-> ##3 !SAFETY_OUTPUT_A) else $error("unknown tag enabled safety");
endmodule : mtse_top_properties
bind mtse_top mtse_top_properties chk_u (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .CLK_EN(CLK_EN),
   .PROGRAM_SEL(PROGRAM_SEL), .SIGNAL_INVERTED(SIGNAL_INVERTED), .TAG_PRESENT(TAG_PRESENT),
   .TAG_INDEX(TAG_INDEX), .SAFETY_INPUT_A(SAFETY_INPUT_A), .SAFETY_INPUT_B(SAFETY_INPUT_B),
   .SAFETY_OUTPUT_A(SAFETY_OUTPUT_A), .SAFETY_OUTPUT_B(SAFETY_OUTPUT_B),
   .SIGNALLING_OUTPUT(SIGNALLING_OUTPUT), .FRAME_BUSY(FRAME_BUSY));

// [test/tb.sv]
// Testbench: self-checking scenarios for the serial encoder
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin #1; checks_done++; if ((got) !== (ex)) begin failures++; \
   $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb;
   import mtse_pkg::*;
   logic CORE_CLK = 1'b0; // Core clock
   logic RESETN = 1'b0; // Sync reset, active low
   mtse_prog_t PROGRAM_SEL = MTSE_BASIC_NO_SIGNAL; // Mode under test
   logic SIGNAL_INVERTED = 1'b0;
   logic TAG_PRESENT = 1'b0;
   logic [3:0] TAG_INDEX = 4'h0;
   logic SAFETY_INPUT_A = 1'b1;
   logic SAFETY_INPUT_B = 1'b1;
   logic SAFETY_OUTPUT_A, SAFETY_OUTPUT_B, SIGNALLING_OUTPUT, FRAME_BUSY;
   logic CLK_EN = 1'b1; // Clock enable under test
   logic [7:0] rx_char;
   logic rx_valid;
   int failures = 0;
   int checks_done = 0;
   mtse_prog_t id_modes [4] = '{MTSE_IDENTIFYING_TWO_TAG_PROGRAM,
      MTSE_IDENTIFYING_THREE_TAG_PROGRAM, MTSE_IDENTIFYING_FOUR_TAG_PROGRAM,
      MTSE_IDENTIFYING_SIXTEEN_TAG_PROGRAM};
   logic [3:0] id_idx [4] = '{4'h1, 4'h2, 4'h3, 4'hF}; // Highest index per mode
   initial forever #2.5 CORE_CLK = ~CORE_CLK;
   mtse_top dut_u (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .CLK_EN(CLK_EN),
      .PROGRAM_SEL(PROGRAM_SEL), .SIGNAL_INVERTED(SIGNAL_INVERTED), .TAG_PRESENT(TAG_PRESENT),
      .TAG_INDEX(TAG_INDEX), .SAFETY_INPUT_A(SAFETY_INPUT_A), .SAFETY_INPUT_B(SAFETY_INPUT_B),
      .SAFETY_OUTPUT_A(SAFETY_OUTPUT_A), .SAFETY_OUTPUT_B(SAFETY_OUTPUT_B),
      .SIGNALLING_OUTPUT(SIGNALLING_OUTPUT), .FRAME_BUSY(FRAME_BUSY));
   mtse_plc_model plc_u (.clk(CORE_CLK), .rst_n(RESETN), .line(SIGNALLING_OUTPUT),
      .rx_char(rx_char), .rx_valid(rx_valid));
   task cyc(input int n);
      repeat (n) @(posedge CORE_CLK);
   endtask : cyc
   task results();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   // Reset with static straps set; strap changes only under reset
   task rst(input mtse_prog_t p, input logic inv, input int n);
      cyc(1);
      RESETN <= 1'b0;
      PROGRAM_SEL <= p;
      SIGNAL_INVERTED <= inv;
      TAG_PRESENT <= 1'b0;
      SAFETY_INPUT_B <= 1'b1;
      cyc(n);
      RESETN <= 1'b1;
      cyc(4);
   endtask : rst
   task tag(input logic [3:0] i);
      TAG_INDEX <= i;
      TAG_PRESENT <= 1'b1;
   endtask : tag
   // Bounded wait for the start bit
   task wait_sig(input int bound);
      int i;
      for (i = 0; i < bound && SIGNALLING_OUTPUT !== 1'b1; i++) begin
         cyc(1);
         #1;
      end
      if (i == bound) begin
         failures++;
         $display("[ERR] start bit exp 1 got %b", SIGNALLING_OUTPUT);
         results();
      end
   endtask : wait_sig
   // Tag loss cuts the frame; the queue then hands over a fresh frame
   task t_requeue();
      rst(MTSE_IDENTIFYING_FOUR_TAG_PROGRAM, 1'b0, 2);
      tag(4'h2);
      wait_sig(20);
      cyc(1);
      TAG_PRESENT <= 1'b0;
      cyc(6);
      `CHK("busy after cut", 1'b0, FRAME_BUSY)
      `CHK("signal after cut", 1'b0, SIGNALLING_OUTPUT)
      cyc(1);
      tag(4'h3);
      wait_sig(20);
      `CHK("busy again", 1'b1, FRAME_BUSY)
   endtask : t_requeue
   task t_basic();
      rst(MTSE_BASIC_NO_SIGNAL, 1'b0, 2);
      tag(4'h0);
      cyc(40);
      `CHK("signal", 1'b0, SIGNALLING_OUTPUT)
      `CHK("busy", 1'b0, FRAME_BUSY)
   endtask : t_basic
   task t_pos();
      rst(MTSE_POSITIONAL_TWO_TAG_PROGRAM, 1'b0, 2);
      tag(4'h0);
      cyc(10);
      `CHK("safety", 2'b11, {SAFETY_OUTPUT_A, SAFETY_OUTPUT_B})
      `CHK("signal", 1'b0, SIGNALLING_OUTPUT)
      cyc(1);
      CLK_EN <= 1'b0;
      SAFETY_INPUT_B <= 1'b0;
      cyc(4);
      `CHK("frozen safety", 2'b11, {SAFETY_OUTPUT_A, SAFETY_OUTPUT_B})
      cyc(1);
      CLK_EN <= 1'b1;
      cyc(4);
      `CHK("safety", 2'b00, {SAFETY_OUTPUT_A, SAFETY_OUTPUT_B})
      cyc(1);
      SAFETY_INPUT_B <= 1'b1;
      TAG_PRESENT <= 1'b0;
      cyc(8);
      tag(4'h1);
      cyc(10);
      `CHK("safety", 2'b00, {SAFETY_OUTPUT_A, SAFETY_OUTPUT_B})
      `CHK("signal", 1'b1, SIGNALLING_OUTPUT)
   endtask : t_pos
   // Start bit opens the stream, holds, and is cut on tag loss
   task t_stream(input int m);
      rst(id_modes[m], 1'b0, 2);
      tag(id_idx[m]);
      wait_sig(20);
      `CHK("safety", 2'b11, {SAFETY_OUTPUT_A, SAFETY_OUTPUT_B})
      `CHK("busy", 1'b1, FRAME_BUSY)
      cyc(1000);
      `CHK("start bit", 1'b1, SIGNALLING_OUTPUT)
      cyc(1);
      TAG_PRESENT <= 1'b0;
      cyc(5);
      `CHK("signal", 1'b0, SIGNALLING_OUTPUT)
   endtask : t_stream
   task t_refuse();
      rst(MTSE_IDENTIFYING_TWO_TAG_PROGRAM, 1'b0, 2);
      tag(4'h5);
      cyc(40);
      `CHK("safety", 2'b00, {SAFETY_OUTPUT_A, SAFETY_OUTPUT_B})
      `CHK("busy", 1'b0, FRAME_BUSY)
   endtask : t_refuse
   task t_inv();
      rst(MTSE_IDENTIFYING_FOUR_TAG_PROGRAM, 1'b1, 2);
      cyc(10);
      `CHK("signal", 1'b1, SIGNALLING_OUTPUT)
   endtask : t_inv
   initial begin
      rst(MTSE_BASIC_NO_SIGNAL, 1'b0, 20);
      t_requeue();
      t_basic();
      t_pos();
      for (int m = 0; m < 4; m++) t_stream(m);
      t_refuse();
      t_inv();
      results();
   end
endmodule : tb
